/* bench/smsp_partner.sv */
// Behavioural far-side serial slave that exchanges one byte per selection.
`timescale 1ns/100ps
module smsp_partner (
   input  wire logic       sck_i,
   input  wire logic       mosi_i,
   input  wire logic       sel_n_i,
   input  wire logic       clock_idle_level_i,
   input  wire logic       clock_phase_select_i,
   input  wire logic [7:0] tx_i,
   output logic            miso_o,
   output logic      [7:0] rx_o
);
   logic [7:0] sh = 8'h00;
   logic       bit_q = 1'b0;

   // Selection loads the reply; with phase zero the first bit is shown at once.
   always @(negedge sel_n_i) begin
      sh    = clock_phase_select_i ? tx_i : {tx_i[6:0], 1'b0};
      bit_q = tx_i[7];
   end

   // Launch edges shift the reply out, the opposite edges take in master data.
   always @(sck_i) begin
      if (!sel_n_i && (sck_i === 1'b0 || sck_i === 1'b1)) begin
         if ((sck_i != clock_idle_level_i) == clock_phase_select_i) begin
            bit_q = sh[7];
            sh    = {sh[6:0], 1'b0};
         end else begin
            rx_o = {rx_o[6:0], mosi_i};
         end
      end
   end

   // A released line shows the inverse of the last bit, so a stale value cannot pass.
   assign miso_o = sel_n_i ? ~bit_q : bit_q;
endmodule

/* bench/smsp_top_tb_top.sv */
// Self-checking bench for the serial port: register access and byte exchanges.
`timescale 1ns/100ps
`define CHK(g, e) begin \
   checks_done++; \
   if ((g) !== (e)) begin \
      failures++; \
      $display("mismatch at %0t: got %h expected %h", $time, g, e); \
   end \
end
module smsp_top_tb_top
   import smsp_pkg::*;
;
   logic       clk_i = 1'b0;
   logic       rst_i = 1'b1;
   logic [7:0] adr = 8'h00;
   logic [7:0] wdat = 8'h00;
   logic       we = 1'b0;
   logic       cyc = 1'b0;
   logic       ss_n = 1'b1;
   logic       far_sel_n = 1'b1;
   logic [7:0] far_tx = 8'h00;
   logic       clock_idle_level = 1'b0;
   logic       clock_phase_select = 1'b0;
   logic [7:0] dat_o;
   logic [7:0] far_rx;
   logic [7:0] st;
   logic       ack, irq, act, od, far_miso, sck_q;
   logic       sck_o, sck_oe_n, mosi_o, mosi_oe_n, miso_o, miso_oe_n;
   logic       sck_w, mosi_w, miso_w;
   int         failures = 0;
   int         checks_done = 0;
   int         cnt = 0;
   int         per_last = 0;

   smsp_top smsp_top_i (
      .clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_dat_o(dat_o),
      .wb_we_i(we), .wb_sel_i(cyc), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_ack_o(ack),
      .irq_o(irq), .serial_clock_pin_i(sck_w), .serial_clock_pin_o(sck_o),
      .serial_clock_pin_oe_n_o(sck_oe_n), .mosi_i(mosi_w), .mosi_o(mosi_o),
      .mosi_oe_n_o(mosi_oe_n), .miso_i(miso_w), .miso_o(miso_o), .miso_oe_n_o(miso_oe_n),
      .slave_select_n_i(ss_n), .port_active_o(act), .open_drain_o(od)
   );

   smsp_partner smsp_partner_i (
      .sck_i(sck_w), .mosi_i(mosi_w), .sel_n_i(far_sel_n), .clock_idle_level_i(clock_idle_level), .clock_phase_select_i(clock_phase_select),
      .tx_i(far_tx), .miso_o(far_miso), .rx_o(far_rx)
   );

   // Each line carries the design's level while it drives, otherwise miso the far side's, sck the idle level and mosi a one.
   assign sck_w  = sck_oe_n ? clock_idle_level : sck_o;
   assign mosi_w = mosi_oe_n ? 1'b1 : mosi_o;
   assign miso_w = miso_oe_n ? far_miso : miso_o;

   // Bus clock of 4 ns.
   initial forever #2 clk_i = ~clk_i;

   // Measures bus clocks between rising serial clock edges.
   always @(posedge clk_i) begin
      sck_q <= sck_w;
      if (sck_w && !sck_q) begin
         per_last <= cnt;
         cnt      <= 1;
      end else begin
         cnt <= cnt + 1;
      end
   end

   // Prints the counts and the verdict, then stops the run.
   task automatic complete_run();
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // One classic bus cycle; read data lands in st at the acknowledging edge.
   task automatic wb(input logic [7:0] a, input logic w, input logic [7:0] d);
      int n;
      n = 0;
      adr  <= a;
      we   <= w;
      wdat <= d;
      cyc  <= 1'b1;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack !== 1'b1 && n < 40);
      if (n >= 40) begin
         failures++;
         complete_run();
      end
      st = dat_o;
      cyc <= 1'b0;
      we  <= 1'b0;
      @(posedge clk_i);
   endtask

   // Reads a register and compares it with the expected byte.
   task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
      wb(a, 1'b0, 8'h00);
      `CHK(st, e)
   endtask

   // Sends one byte and polls status until the given flag rises.
   task automatic xfer(input logic [7:0] mine, input logic [7:0] theirs, input int flag);
      int n;
      far_tx    <= theirs;
      far_sel_n <= 1'b0;
      @(posedge clk_i);
      wb(SMSP_ADDR_STATUS, 1'b0, 8'h00);
      `CHK(st[SMSP_S_TXE], 1'b1)
      wb(SMSP_ADDR_DATA, 1'b1, mine);
      n = 0;
      do begin
         wb(SMSP_ADDR_STATUS, 1'b0, 8'h00);
         n++;
      end while (st[flag] !== 1'b1 && n < 500);
      if (n >= 500) begin
         failures++;
         complete_run();
      end
      far_sel_n <= 1'b1;
      `CHK(far_rx, mine)
   endtask

   // Main sequence of register and transfer tests.
   initial begin
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      rdchk(SMSP_ADDR_CONTROL, 8'h28);
      wb(SMSP_ADDR_STATUS, 1'b0, 8'h00);
      `CHK(st & 8'hFB, 8'h08)
      rdchk(8'h13, 8'h00);
      `CHK({irq, sck_oe_n, mosi_oe_n, miso_oe_n}, 4'h7)
      wb(SMSP_ADDR_CONTROL, 1'b1, 8'h2C);
      `CHK(od, 1'b1)
      for (int r = 0; r < 4; r++) begin
         clock_idle_level <= r[1];
         clock_phase_select <= r[0];
         wb(SMSP_ADDR_STATUS, 1'b1, {6'h00, r[1], r[0]});
         wb(SMSP_ADDR_CONTROL, 1'b1, {3'b001, r[1], r[0], 3'b010});
         `CHK({act, sck_oe_n, sck_o}, {1'b1, 1'b0, r[1]})
         xfer(8'hA5 ^ 8'(r), 8'h3C + 8'(r), SMSP_S_RXF);
         `CHK(per_last, 2 << (2 * r))
         rdchk(SMSP_ADDR_DATA, 8'h3C + 8'(r));
         wb(SMSP_ADDR_STATUS, 1'b0, 8'h00);
         `CHK(st[SMSP_S_RXF], 1'b0)
      end
      clock_idle_level <= 1'b0;
      wb(SMSP_ADDR_STATUS, 1'b1, 8'h40);
      wb(SMSP_ADDR_CONTROL, 1'b1, 8'hAA);
      xfer(8'h11, 8'h77, SMSP_S_RXF);
      `CHK(irq, 1'b1)
      xfer(8'h22, 8'h99, SMSP_S_OVR);
      wb(SMSP_ADDR_CONTROL, 1'b1, 8'h2A);
      `CHK(irq, 1'b1)
      rdchk(SMSP_ADDR_STATUS, 8'hE8);
      rdchk(SMSP_ADDR_DATA, 8'h77);
      rdchk(SMSP_ADDR_STATUS, 8'h48);
      `CHK(irq, 1'b0)
      wb(SMSP_ADDR_CONTROL, 1'b1, 8'h2B);
      `CHK(irq, 1'b1)
      wb(SMSP_ADDR_CONTROL, 1'b1, 8'h2A);
      `CHK(irq, 1'b0)
      wb(SMSP_ADDR_STATUS, 1'b1, 8'h00);
      ss_n <= 1'b0;
      repeat (4) @(posedge clk_i);
      wb(SMSP_ADDR_STATUS, 1'b0, 8'h00);
      `CHK(st[SMSP_S_MODE_FAULT_FLAG], 1'b0)
      ss_n <= 1'b1;
      repeat (2) @(posedge clk_i);
      wb(SMSP_ADDR_STATUS, 1'b1, 8'h04);
      ss_n <= 1'b0;
      repeat (4) @(posedge clk_i);
      ss_n <= 1'b1;
      wb(SMSP_ADDR_STATUS, 1'b0, 8'h00);
      `CHK(st[SMSP_S_MODE_FAULT_FLAG], 1'b1)
      wb(SMSP_ADDR_STATUS, 1'b1, 8'h00);
      wb(SMSP_ADDR_STATUS, 1'b0, 8'h00);
      `CHK(st[SMSP_S_MODE_FAULT_FLAG], 1'b1)
      wb(SMSP_ADDR_CONTROL, 1'b1, 8'h2A);
      wb(SMSP_ADDR_STATUS, 1'b0, 8'h00);
      `CHK(st[SMSP_S_MODE_FAULT_FLAG], 1'b0)
      xfer(8'h5A, 8'hC3, SMSP_S_RXF);
      wb(SMSP_ADDR_CONTROL, 1'b1, 8'h28);
      `CHK({act, sck_oe_n, mosi_oe_n, miso_oe_n, irq}, 5'h0E)
      rdchk(SMSP_ADDR_CONTROL, 8'h28);
      rdchk(SMSP_ADDR_STATUS, 8'h88);
      rdchk(SMSP_ADDR_DATA, 8'hC3);
      wb(SMSP_ADDR_CONTROL, 1'b1, 8'h0A);
      `CHK({sck_oe_n, miso_oe_n}, 2'h3)
      complete_run();
   end
endmodule

/* hdl/smsp_pkg.sv */
// Package with register map, field layout and shared types of the serial port.
package smsp_pkg;
   // Byte addresses of the registers on the bus.
   localparam logic [7:0] SMSP_ADDR_CONTROL = 8'h10;
   localparam logic [7:0] SMSP_ADDR_STATUS  = 8'h11;
   localparam logic [7:0] SMSP_ADDR_DATA    = 8'h12;
   // Control register fields.
   localparam int SMSP_C_RXIE  = 7;
   localparam int SMSP_C_MSTR  = 5;
   localparam int SMSP_C_CLOCK_IDLE_LEVEL  = 4;
   localparam int SMSP_C_CLOCK_PHASE_SELECT  = 3;
   localparam int SMSP_C_WOM   = 2;
   localparam int SMSP_C_EN    = 1;
   localparam int SMSP_C_TXIE  = 0;
   // Status and control register fields.
   localparam int SMSP_S_RXF   = 7;
   localparam int SMSP_S_ERROR_IRQ_ENABLE = 6;
   localparam int SMSP_S_OVR   = 5;
   localparam int SMSP_S_MODE_FAULT_FLAG  = 4;
   localparam int SMSP_S_TXE   = 3;
   localparam int SMSP_S_MFEN  = 2;
   localparam int SMSP_S_RATE  = 0;
   localparam logic [7:0] SMSP_CONTROL_RESET = 8'h28;
   localparam logic [7:0] SMSP_CONTROL_WMASK = 8'hBF;
   localparam logic [7:0] SMSP_STATUS_WMASK  = 8'h47;
   localparam int SMSP_BITS_PER_BYTE = 8;
   // Half-period lengths in bus clocks less one, for each rate code.
   localparam logic [5:0] SMSP_HALF_DIV2   = 6'h00;
   localparam logic [5:0] SMSP_HALF_DIV8   = 6'h03;
   localparam logic [5:0] SMSP_HALF_DIV32  = 6'h0F;
   localparam logic [5:0] SMSP_HALF_DIV128 = 6'h3F;

   // Control settings passed to the shift engine.
   typedef struct packed {
      logic       master;
      logic       clock_idle_level;
      logic       clock_phase_select;
      logic       enable;
      logic       mf_enable;
      logic [1:0] rate;
   } smsp_cfg_t;

   // Pin outputs with active-low enables.
   typedef struct packed {
      logic sck_o;
      logic sck_oe_n;
      logic mosi_o;
      logic mosi_oe_n;
      logic miso_o;
      logic miso_oe_n;
   } smsp_pins_t;
endpackage

/* hdl/smsp_rate.sv */
// Rate divider producing half-period enable pulses for the master clock.
`timescale 1ns/100ps
module smsp_rate
   import smsp_pkg::*;
(
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire logic       run_i,
   input  wire logic [1:0] rate_i,
   output logic            tick_o
);
   logic [5:0] count;
   logic [5:0] limit;

   // Maps the rate code to a half-period length.
   always_comb begin
      unique case (rate_i)
         2'b00: limit = SMSP_HALF_DIV2;
         2'b01: limit = SMSP_HALF_DIV8;
         2'b10: limit = SMSP_HALF_DIV32;
         2'b11: limit = SMSP_HALF_DIV128;
      endcase
   end

   // Counts bus clocks and pulses once per half serial period.
   always_ff @(posedge clk_i) begin
      if (rst_i || !run_i) begin
         count <= '0;
      end else if (count >= limit) begin
         count <= '0;
      end else begin
         count <= count + 6'h01;
      end
   end

   assign tick_o = run_i && (count >= limit);

   chk_rate_tick_gap: assert property (@(posedge clk_i) disable iff (rst_i)
      tick_o && rate_i == 2'b01 && run_i |=> !tick_o [*3])
      else $error("divide by eight tick came too early");
endmodule

/* hdl/smsp_sync.sv */
// Two-flip-flop synchroniser for the incoming serial pins.
`timescale 1ns/100ps
module smsp_sync
   import smsp_pkg::*;
#(
   parameter int WIDTH = 4
) (
   input  wire logic             clk_i,
   input  wire logic             rst_i,
   input  wire logic [WIDTH-1:0] async_i,
   output logic      [WIDTH-1:0] sync_o
);
   logic [WIDTH-1:0] stage1;

   // Only the second stage reads the first.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         stage1 <= '1;
         sync_o <= '1;
      end else begin
         stage1 <= async_i;
         sync_o <= stage1;
      end
   end
endmodule

/* hdl/smsp_top.sv */
// Serial port with master and slave modes behind a classic Wishbone slave.
`timescale 1ns/100ps
module smsp_top
   import smsp_pkg::*;
(
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire logic [7:0] wb_adr_i,
   input  wire logic [7:0] wb_dat_i,
   output logic      [7:0] wb_dat_o,
   input  wire logic       wb_we_i,
   input  wire logic       wb_sel_i,
   input  wire logic       wb_cyc_i,
   input  wire logic       wb_stb_i,
   output logic            wb_ack_o,
   output logic            irq_o,
   input  wire logic       serial_clock_pin_i,
   output logic            serial_clock_pin_o,
   output logic            serial_clock_pin_oe_n_o,
   input  wire logic       mosi_i,
   output logic            mosi_o,
   output logic            mosi_oe_n_o,
   input  wire logic       miso_i,
   output logic            miso_o,
   output logic            miso_oe_n_o,
   input  wire logic       slave_select_n_i,
   output logic            port_active_o,
   output logic            open_drain_o
);
   typedef enum logic [3:0] {
      SMSP_IDLE  = 4'b0001,
      SMSP_SHIFT = 4'b0010,
      SMSP_DRAIN = 4'b0100,
      SMSP_DONE  = 4'b1000
   } smsp_state_t;

   logic [7:0]  control;
   logic [2:0]  status_ctl;
   logic        rx_full_flag;
   logic        overrun_flag;
   logic        mode_fault_flag;
   logic        tx_empty_flag;
   logic [7:0]  tx_data;
   logic [7:0]  rx_data;
   logic [7:0]  shifter;
   logic [3:0]  edge_count;
   logic        sck_level;
   logic        out_bit;
   logic        seen_rx;
   logic        seen_ovr;
   logic        seen_mode_fault_flag;
   logic [3:0]  pins_sync;
   logic        sck_s;
   logic        mosi_s;
   logic        miso_s;
   logic        ss_s;
   logic        sck_prev;
   logic        ss_prev;
   logic        tick;
   logic        acc;
   logic        rd_status;
   logic        rd_data;
   logic        wr_control;
   logic        wr_data;
   logic        load_tx;
   logic        byte_done;
   logic        slave_edge;
   logic        take_now;
   logic        take_in;
   logic [1:0]  take_dly;
   logic [7:0]  tx_shift;
   logic [3:0]  in_count;
   logic        error_irq_enable;
   logic        sample_in;
   logic        master_fault;
   logic        slave_fault;
   logic        in_bit;
   smsp_state_t state;
   smsp_cfg_t   cfg;

   // Control settings gathered for the shift engine.
   assign cfg = '{master:    control[SMSP_C_MSTR],
                  clock_idle_level:      control[SMSP_C_CLOCK_IDLE_LEVEL],
                  clock_phase_select:      control[SMSP_C_CLOCK_PHASE_SELECT],
                  enable:    control[SMSP_C_EN],
                  mf_enable: status_ctl[SMSP_S_MFEN],
                  rate:      status_ctl[SMSP_S_RATE +: 2]};

   // Bus strobes; every access is answered, unmapped reads return zero.
   assign acc        = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign rd_status  = acc && !wb_we_i && wb_adr_i == SMSP_ADDR_STATUS;
   assign rd_data    = acc && !wb_we_i && wb_adr_i == SMSP_ADDR_DATA;
   assign wr_control = acc && wb_we_i && wb_sel_i && wb_adr_i == SMSP_ADDR_CONTROL;
   assign wr_data    = acc && wb_we_i && wb_sel_i && wb_adr_i == SMSP_ADDR_DATA;

   // Acknowledge one cycle after the request, then drop.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= acc;
      end
   end

   // Read data mux; the data address returns received bytes only.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_dat_o <= 8'h00;
      end else if (acc && !wb_we_i) begin
         unique case (wb_adr_i)
            SMSP_ADDR_CONTROL: wb_dat_o <= control;
            SMSP_ADDR_STATUS:  wb_dat_o <= {rx_full_flag, error_irq_enable, overrun_flag,
                                            mode_fault_flag, tx_empty_flag, status_ctl};
            SMSP_ADDR_DATA:    wb_dat_o <= rx_data;
            default:           wb_dat_o <= 8'h00;
         endcase
      end
   end

   // Control register; only system reset restores it.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         control <= SMSP_CONTROL_RESET;
      end else if (wr_control) begin
         control <= wb_dat_i & SMSP_CONTROL_WMASK;
      end
   end

   // Status control bits: mode fault enable and rate code.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         status_ctl <= 3'h0;
      end else if (acc && wb_we_i && wb_sel_i && wb_adr_i == SMSP_ADDR_STATUS) begin
         status_ctl <= wb_dat_i[2:0];
      end
   end

   // Error enable lives separately since it sits among the flags.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         error_irq_enable <= 1'b0;
      end else if (acc && wb_we_i && wb_sel_i && wb_adr_i == SMSP_ADDR_STATUS) begin
         error_irq_enable <= wb_dat_i[SMSP_S_ERROR_IRQ_ENABLE];
      end
   end

   // Remembers which flags a status read saw set.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         seen_rx   <= 1'b0;
         seen_ovr  <= 1'b0;
         seen_mode_fault_flag <= 1'b0;
      end else if (rd_status) begin
         seen_rx   <= rx_full_flag;
         seen_ovr  <= overrun_flag;
         seen_mode_fault_flag <= mode_fault_flag;
      end else begin
         if (rd_data) begin
            seen_rx  <= 1'b0;
            seen_ovr <= 1'b0;
         end
         if (wr_control) begin
            seen_mode_fault_flag <= 1'b0;
         end
      end
   end

   // Pin synchroniser.
   smsp_sync #(.WIDTH(4)) u_sync (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .async_i ({serial_clock_pin_i, mosi_i, miso_i, slave_select_n_i}),
      .sync_o  (pins_sync)
   );
   assign {sck_s, mosi_s, miso_s, ss_s} = pins_sync;

   // Master clock half-period pulses.
   smsp_rate u_rate (
      .clk_i  (clk_i),
      .rst_i  (rst_i),
      .run_i  (cfg.enable && cfg.master && state == SMSP_SHIFT),
      .rate_i (cfg.rate),
      .tick_o (tick)
   );

   // Past values for edge detection.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sck_prev <= 1'b1; // Matches the synchroniser's reset level, so no false edge.
         ss_prev  <= 1'b1;
      end else begin
         sck_prev <= sck_s;
         ss_prev  <= ss_s;
      end
   end

   // Slave edges count only while selected.
   assign slave_edge = !cfg.master && !ss_s && (sck_s != sck_prev);
   assign sample_in  = cfg.master ? tick : slave_edge;
   // Master samples wait two clocks for the pin synchroniser to catch up.
   assign take_now   = state == SMSP_SHIFT && sample_in && edge_count[0] == cfg.clock_phase_select;
   assign take_in    = cfg.master ? take_dly[1] : take_now;
   assign in_bit     = cfg.master ? miso_s : mosi_s;
   assign load_tx    = cfg.enable && state == SMSP_IDLE && !tx_empty_flag
                       && (cfg.master || !ss_s);
   assign byte_done  = state == SMSP_DONE;
   assign master_fault = cfg.enable && cfg.master && cfg.mf_enable && !ss_s;
   assign slave_fault  = cfg.enable && !cfg.master && cfg.mf_enable
                         && state == SMSP_SHIFT && ss_s && !ss_prev;

   // Delays master sample strobes by the depth of the pin synchroniser.
   always_ff @(posedge clk_i) begin
      if (rst_i || !cfg.enable || master_fault) begin
         take_dly <= 2'b00;
      end else begin
         take_dly <= {take_dly[0], take_now && cfg.master};
      end
   end

   // Shift engine: sixteen clock edges send one byte, then the last samples drain in.
   always_ff @(posedge clk_i) begin
      if (rst_i || !cfg.enable || master_fault) begin
         state      <= SMSP_IDLE;
         shifter    <= 8'h00;
         tx_shift   <= 8'h00;
         edge_count <= 4'h0;
         in_count   <= 4'h0;
         sck_level  <= 1'b0;
         out_bit    <= 1'b0;
      end else begin
         if (take_in) begin
            shifter  <= {shifter[6:0], in_bit};
            in_count <= in_count + 4'h1;
         end
         unique case (state)
            SMSP_IDLE: begin
               sck_level <= 1'b0;
               if (load_tx) begin
                  tx_shift   <= cfg.clock_phase_select ? tx_data : {tx_data[6:0], 1'b0};
                  out_bit    <= tx_data[7];
                  edge_count <= 4'h0;
                  in_count   <= 4'h0;
                  state      <= SMSP_SHIFT;
               end
            end
            SMSP_SHIFT: begin
               if (sample_in) begin
                  sck_level  <= ~sck_level;
                  edge_count <= edge_count + 4'h1;
                  // Launch edges put out the next bit; phase one launches on the first edge.
                  if (edge_count[0] != cfg.clock_phase_select) begin
                     out_bit  <= tx_shift[7];
                     tx_shift <= {tx_shift[6:0], 1'b0};
                  end
                  if (edge_count == 4'(2 * SMSP_BITS_PER_BYTE - 1)) begin
                     state <= SMSP_DRAIN;
                  end
               end
            end
            SMSP_DRAIN: begin
               // Waits until all eight samples, delayed in master mode, have entered the shifter.
               if (in_count == 4'(SMSP_BITS_PER_BYTE)) begin
                  state <= SMSP_DONE;
               end
            end
            SMSP_DONE: begin
               state <= SMSP_IDLE;
            end
            default: state <= SMSP_IDLE;
         endcase
      end
   end

   // Transmit register keeps its contents across reset.
   always_ff @(posedge clk_i) begin
      if (wr_data && tx_empty_flag) begin
         tx_data <= wb_dat_i;
      end
   end

   // Receive register keeps the old byte on overrun.
   always_ff @(posedge clk_i) begin
      if (byte_done && !rx_full_flag) begin
         rx_data <= shifter;
      end
   end

   // Transmit-empty flag; partial reset sets it.
   always_ff @(posedge clk_i) begin
      if (rst_i || !cfg.enable) begin
         tx_empty_flag <= 1'b1;
      end else if (load_tx) begin
         tx_empty_flag <= 1'b1;
      end else if (wr_data) begin
         tx_empty_flag <= 1'b0;
      end
   end

   // Receive-full flag; the clearing read wins over a byte that completes while it is set.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rx_full_flag <= 1'b0;
      end else if (byte_done && !rx_full_flag) begin
         rx_full_flag <= 1'b1;
      end else if (rd_data && seen_rx) begin
         rx_full_flag <= 1'b0;
      end
   end

   // Overrun flag.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         overrun_flag <= 1'b0;
      end else if (byte_done && rx_full_flag) begin
         overrun_flag <= 1'b1;
      end else if (rd_data && seen_ovr) begin
         overrun_flag <= 1'b0;
      end
   end

   // Mode fault flag; disabling detection does not clear it.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mode_fault_flag <= 1'b0;
      end else if (master_fault || slave_fault) begin
         mode_fault_flag <= 1'b1;
      end else if (wr_control && seen_mode_fault_flag) begin
         mode_fault_flag <= 1'b0;
      end
   end

   // Interrupt request from enabled flags.
   assign irq_o = (rx_full_flag && control[SMSP_C_RXIE])
                || (tx_empty_flag && control[SMSP_C_TXIE])
                || ((overrun_flag || mode_fault_flag) && error_irq_enable);

   // Pin drive; enables are active low, open drain drives only low.
   always_comb begin
      serial_clock_pin_o      = sck_level ^ cfg.clock_idle_level;
      mosi_o                  = out_bit;
      miso_o                  = out_bit;
      serial_clock_pin_oe_n_o = !(cfg.enable && cfg.master);
      mosi_oe_n_o             = !(cfg.enable && cfg.master);
      miso_oe_n_o             = !(cfg.enable && !cfg.master && !ss_s);
      if (control[SMSP_C_WOM]) begin
         serial_clock_pin_oe_n_o = serial_clock_pin_oe_n_o || serial_clock_pin_o;
         mosi_oe_n_o             = mosi_oe_n_o || mosi_o;
         miso_oe_n_o             = miso_oe_n_o || miso_o;
      end
   end

   assign port_active_o = cfg.enable;
   assign open_drain_o  = control[SMSP_C_WOM];

   chk_rx_set_on_done: assert property (@(posedge clk_i) disable iff (rst_i)
      byte_done && !rx_full_flag |=> rx_full_flag)
      else $error("receive full not set after byte");
   chk_ovr_keeps_data: assert property (@(posedge clk_i) disable iff (rst_i)
      byte_done && rx_full_flag |=> overrun_flag && $stable(rx_data))
      else $error("overrun not flagged or data overwritten");
   chk_tx_clear_write: assert property (@(posedge clk_i) disable iff (rst_i)
      wr_data && tx_empty_flag && !load_tx && cfg.enable |=> !tx_empty_flag)
      else $error("transmit empty not cleared by write");
   chk_disable_resets: assert property (@(posedge clk_i) disable iff (rst_i)
      !cfg.enable |=> state == SMSP_IDLE && tx_empty_flag)
      else $error("partial reset incomplete");
   chk_mode_fault_flag_master: assert property (@(posedge clk_i) disable iff (rst_i)
      master_fault |=> mode_fault_flag)
      else $error("master mode fault missed");
   chk_irq_rx_gate: assert property (@(posedge clk_i) disable iff (rst_i)
      rx_full_flag && control[SMSP_C_RXIE] |-> irq_o)
      else $error("receive interrupt missing");
   chk_irq_err_gate: assert property (@(posedge clk_i) disable iff (rst_i)
      irq_o |-> rx_full_flag || tx_empty_flag || overrun_flag || mode_fault_flag)
      else $error("interrupt without a flag");
   chk_miso_deselect: assert property (@(posedge clk_i) disable iff (rst_i)
      ss_s && !cfg.master |-> miso_oe_n_o)
      else $error("master in driven while deselected");
   chk_mode_fault_flag_clear_step: assert property (@(posedge clk_i) disable iff (rst_i)
      wr_control && !seen_mode_fault_flag && !master_fault && !slave_fault && mode_fault_flag
      |=> mode_fault_flag)
      else $error("mode fault cleared without status read");
endmodule
